// ==== hdl/hrs_top.sv ====
`timescale 1ns/10ps
// Contract
// - both counters hold 18 bits, true form
// - each counter loads on its load strobe
// - counters increment by one in binary
// - fetch counts with enable and repeat mode
// - counters drive bus on active-low read
// - fetch sign falling clears repeat mode
// - table sign falling sets stop flip-flop
// - negative-not-minus-one feeds tests 10, 11
// - j-condition group op counts both once
// - status read shows conditions bits 26, 27
// - order word loads and reads on strobes
// - command strobe copies upper 16 bits out
// - flag word loads bits 18-21,28,29,33
// - clipper sets touch/aux; host clears touch
// - flags always visible, readable onto bus
// - instruction bits 14-17 select test condition
// - two latches remember host stop requests
// - interrupt line ORs four stop causes
// - stop requests synchronised to clock
// - one-of-8 decode gives read, load strobes
// - loads need write or conditional write with bit 13 clear
// - register 15 read also on memaddr path
// - instruction bit 13 inverts condition sense
module hrs_top
  import hrs_pkg::*;
(
  input wire logic REF_CLK, // processor clock
  input wire logic SYS_RST, // sync reset, high
  input wire logic [0:35] REGISTER_INPUT_BUS, // internal input bus
  input wire logic [0:17] INSTRUCTION_LATCH, // instruction bits
  input wire logic [2:0] HIGH_REG_ADDR, // higher register select
  input wire logic READ_REQ, // read of addressed register
  input wire logic WRITE_REQ, // unconditional write
  input wire logic CONDITIONAL_STORE_REQ, // write if bit 13 clear
  input wire logic MEMADDR_TO_REGISTER_PATH, // read memaddr as 15
  input wire logic FETCH_COUNT_ENABLE, // count fetch counter
  input wire logic TABLE_COUNT_ENABLE, // count table counter
  input wire logic REPEAT_MODE_ACTIVE, // repeat mode flag
  input wire logic J_CONDITION_MODE, // j-conditions mode
  input wire logic CONDITION_GROUP_ACTIVE, // group 2 condition_group_active
  input wire logic COMMAND_LATCH_STROBE, // copy order to lines
  input wire logic MEM_TO_MEM, // memory-to-memory transfer
  input wire logic HALT_ON_TOUCH, // stop on touch enable
  input wire logic HOST_CONTROL_STROBE, // host, async
  input wire logic HOST_SET_STOP, // host, async
  input wire logic HOST_CLEAR_STOP, // host, async
  input wire logic HOST_STEP, // host, async
  input wire logic CLIPPER_CLOCK_PULSE, // clipper, async, low
  input wire logic CLIPPER_SET_TOUCH, // clipper, async
  input wire logic CLIPPER_SET_AUX, // clipper, async
  input wire logic CLIPPER_CLEAR_AUX, // clipper, async
  input wire logic CLEAR_TOUCH_REQUEST, // host, async
  input wire logic BAD_SLAVE_SELECT, // clipper fault, async
  input wire logic [0:35] SHARED_READ_BUS_I, // wire level
  output logic [0:35] SHARED_READ_BUS_O, // own wired-and value
  output logic [0:35] SHARED_READ_BUS_OE, // pull low where set
  output logic INTERRUPT_OR_LINE_O, // always low when driven
  output logic INTERRUPT_OR_LINE_OE, // pull interrupt low
  output logic [0:7] READ_STROBES_N, // per-register read, low
  output logic [0:7] LOAD_STROBES, // per-register load
  output logic CONDITION_TEST_LINE, // selected test condition
  output logic COND_OK, // test result after inversion
  output logic [0:6] FLAG_STATUS_WORD, // flag word outputs
  output logic [0:15] EXTERNAL_ORDER_LINES, // command latch
  output logic REPEAT_CLEAR, // pulse: leave repeat mode
  output logic PROC_STOP, // synchronised stop
  output logic HOST_STOP_SET, // stop latch state
  output logic HOST_STEP_SET // step latch state
);

  logic [0:17] fetch_ff, nxt_fetch;
  logic [0:17] table_ff, nxt_table;
  logic [0:17] order_ff;
  logic [0:15] cmd_ff;
  logic [0:6] flag_ff, nxt_flag;
  logic fetch_sign_ff, table_sign_ff;
  logic rpt_clr_ff, stop_ff, io_stop_ff, step_ff, clip_prev_ff;
  logic [ASYNC_W-1:0] async_in;
  logic [ASYNC_W-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [0:7] sel;
  logic load_ok, fetch_neg, table_neg, clip_edge, intr_any;
  logic fetch_cnt, table_cnt;
  logic [0:35] bus_val;

  // the far ends run on their own clocks
  assign async_in = {BAD_SLAVE_SELECT, CLEAR_TOUCH_REQUEST,
    CLIPPER_CLEAR_AUX, CLIPPER_SET_AUX, CLIPPER_SET_TOUCH,
    CLIPPER_CLOCK_PULSE, HOST_STEP, HOST_CLEAR_STOP,
    HOST_SET_STOP, HOST_CONTROL_STROBE};

  // three-stage sync; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < ASYNC_W; gi++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
          s1_ff[gi] <= 1'b0;
          s2_ff[gi] <= 1'b0;
          s3_ff[gi] <= 1'b0;
          flt_ff[gi] <= 1'b0;
        end else begin
          s1_ff[gi] <= async_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            flt_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // address decode into strobes
  assign load_ok = WRITE_REQ | (CONDITIONAL_STORE_REQ &
    ~INSTRUCTION_LATCH[COND_INV_BIT]);
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dec
      assign sel[gi] = (HIGH_REG_ADDR == 3'(gi));
      assign LOAD_STROBES[gi] = sel[gi] & load_ok;
      if (gi == REG_MEMADDR) begin : g_ma
        assign READ_STROBES_N[gi] = ~((READ_REQ & sel[gi]) |
          MEMADDR_TO_REGISTER_PATH);
      end else begin : g_rd
        assign READ_STROBES_N[gi] = ~(READ_REQ & sel[gi]);
      end
    end
  endgenerate

  // count enables; a group 2 j-condition step counts both once
  assign fetch_cnt = (FETCH_COUNT_ENABLE & REPEAT_MODE_ACTIVE) |
    (CONDITION_GROUP_ACTIVE & J_CONDITION_MODE);
  assign table_cnt = TABLE_COUNT_ENABLE |
    (CONDITION_GROUP_ACTIVE & J_CONDITION_MODE);

  // load wins over count in the same cycle
  always_comb begin
    nxt_fetch = fetch_ff;
    if (LOAD_STROBES[REG_FETCH]) begin
      nxt_fetch = REGISTER_INPUT_BUS[18:35];
    end else if (fetch_cnt) begin
      nxt_fetch = fetch_ff + 18'h00001;
    end
  end

  always_comb begin
    nxt_table = table_ff;
    if (LOAD_STROBES[REG_TABLE]) begin
      nxt_table = REGISTER_INPUT_BUS[18:35];
    end else if (table_cnt) begin
      nxt_table = table_ff + 18'h00001;
    end
  end

  // counters and their sign history
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      fetch_ff <= CNT_RST;
      table_ff <= CNT_RST;
      fetch_sign_ff <= 1'b0;
      table_sign_ff <= 1'b0;
    end else begin
      fetch_ff <= nxt_fetch;
      table_ff <= nxt_table;
      fetch_sign_ff <= fetch_ff[0];
      table_sign_ff <= table_ff[0];
    end
  end

  // repeat mode ends when the fetch count turns non-negative
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rpt_clr_ff <= 1'b0;
    end else begin
      rpt_clr_ff <= fetch_sign_ff & ~fetch_ff[0];
    end
  end
  assign REPEAT_CLEAR = rpt_clr_ff;

  // negative but not minus one
  assign fetch_neg = fetch_ff[0] & ~(&fetch_ff);
  assign table_neg = table_ff[0] & ~(&table_ff);

  // order word and the command latch; latch takes the old word
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      order_ff <= CNT_RST;
      cmd_ff <= CMD_RST;
    end else begin
      if (LOAD_STROBES[REG_ORDER]) begin
        order_ff <= REGISTER_INPUT_BUS[18:35];
      end
      if (COMMAND_LATCH_STROBE) begin
        cmd_ff <= order_ff[0:15];
      end
    end
  end
  assign EXTERNAL_ORDER_LINES = cmd_ff;

  // acts on the clipper clock's fall; prev resets to the low idle level
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      clip_prev_ff <= 1'b0;
    end else begin
      clip_prev_ff <= flt_ff[AI_CLIPCLK];
    end
  end
  assign clip_edge = clip_prev_ff & ~flt_ff[AI_CLIPCLK];

  // flag word: sets from the clipper win over loads and clears
  always_comb begin
    nxt_flag = flag_ff;
    if (LOAD_STROBES[REG_FLAGS]) begin
      nxt_flag = {REGISTER_INPUT_BUS[FLAG_LO:FLAG_LO+3],
        REGISTER_INPUT_BUS[TOUCH_BIT], REGISTER_INPUT_BUS[AUX_BIT],
        REGISTER_INPUT_BUS[STOP_BIT]};
    end
    if (flt_ff[AI_CLRTOUCH] & flt_ff[AI_HOST]) begin
      nxt_flag[FW_TOUCH] = 1'b0;
    end
    if (clip_edge & flt_ff[AI_CLRAUX]) begin
      nxt_flag[FW_AUX] = 1'b0;
    end
    if (clip_edge & flt_ff[AI_SETTOUCH]) begin
      nxt_flag[FW_TOUCH] = 1'b1;
    end
    if (clip_edge & flt_ff[AI_SETAUX]) begin
      nxt_flag[FW_AUX] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      flag_ff <= FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
  assign FLAG_STATUS_WORD = flag_ff;

  // test selection; unused codes report false
  always_comb begin
    CONDITION_TEST_LINE = 1'b0;
    unique case (INSTRUCTION_LATCH[14:17])
      4'h0, 4'h1, 4'h2, 4'h3:
        CONDITION_TEST_LINE = flag_ff[INSTRUCTION_LATCH[16:17]];
      TS_FETCH: CONDITION_TEST_LINE = fetch_neg;
      TS_TABLE: CONDITION_TEST_LINE = table_neg;
      TS_TOUCH: CONDITION_TEST_LINE = flag_ff[FW_TOUCH];
      TS_AUX: CONDITION_TEST_LINE = flag_ff[FW_AUX];
      TS_STOP: CONDITION_TEST_LINE = flag_ff[FW_STOP];
      default: CONDITION_TEST_LINE = 1'b0;
    endcase
  end
  assign COND_OK = CONDITION_TEST_LINE ^
    INSTRUCTION_LATCH[COND_INV_BIT];

  // shared bus: each reader ands in its word, the flag read sets bits 26-29, 33 outright; idle rests high
  always_comb begin
    bus_val = BUS_IDLE;
    if (!READ_STROBES_N[REG_FETCH]) begin
      bus_val[18:35] = bus_val[18:35] & fetch_ff;
    end
    if (!READ_STROBES_N[REG_TABLE]) begin
      bus_val[18:35] = bus_val[18:35] & table_ff;
    end
    if (!READ_STROBES_N[REG_ORDER]) begin
      bus_val[18:35] = bus_val[18:35] & order_ff;
    end
    if (!READ_STROBES_N[REG_FLAGS]) begin
      bus_val[FLAG_LO:FLAG_LO+3] = bus_val[FLAG_LO:FLAG_LO+3] &
        flag_ff[0:3];
      bus_val[TOUCH_BIT] = flag_ff[FW_TOUCH];
      bus_val[AUX_BIT] = flag_ff[FW_AUX];
      bus_val[STOP_BIT] = flag_ff[FW_STOP];
      bus_val[FETCH_COND_BIT] = fetch_neg;
      bus_val[TABLE_COND_BIT] = table_neg;
    end
  end
  assign SHARED_READ_BUS_O = bus_val;
  assign SHARED_READ_BUS_OE = ~bus_val; // open collector pulls zeros

  // interrupt causes; table term uses the sign after it clears
  assign intr_any = flt_ff[AI_BADSLAVE] |
    (MEM_TO_MEM & ~table_ff[0]) |
    (flag_ff[FW_TOUCH] & HALT_ON_TOUCH) | flag_ff[FW_STOP];
  assign INTERRUPT_OR_LINE_O = 1'b0;
  assign INTERRUPT_OR_LINE_OE = intr_any;

  // host stop latches; a set in the clear cycle is kept
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      io_stop_ff <= 1'b0;
      step_ff <= 1'b0;
    end else begin
      if (flt_ff[AI_SETSTOP]) begin
        io_stop_ff <= 1'b1;
      end else if (flt_ff[AI_CLRSTOP]) begin
        io_stop_ff <= 1'b0;
      end
      if (flt_ff[AI_STEP]) begin
        step_ff <= 1'b1;
      end else if (flt_ff[AI_CLRSTOP]) begin
        step_ff <= 1'b0;
      end
    end
  end
  assign HOST_STOP_SET = io_stop_ff;
  assign HOST_STEP_SET = step_ff;

  // stop is taken only at a clock edge so the halt is clean
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stop_ff <= 1'b0;
    end else if (io_stop_ff | step_ff | intr_any) begin
      stop_ff <= 1'b1;
    end else if (table_sign_ff & ~table_ff[0]) begin
      stop_ff <= 1'b1;
    end else if (flt_ff[AI_CLRSTOP]) begin
      stop_ff <= 1'b0;
    end
  end
  assign PROC_STOP = stop_ff;

  property p_load_fetch;
    @(posedge REF_CLK) disable iff (SYS_RST)
      LOAD_STROBES[REG_FETCH] |=> fetch_ff == $past(REGISTER_INPUT_BUS[18:35]);
  endproperty
  a_load_fetch: assert property (p_load_fetch)
    else $error("fetch counter did not load");

  property p_count_table;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (TABLE_COUNT_ENABLE & ~LOAD_STROBES[REG_TABLE])
        |=> table_ff == 18'($past(table_ff) + 18'h00001);
  endproperty
  a_count_table: assert property (p_count_table)
    else $error("table counter did not step by one");

  property p_fetch_hold;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (~REPEAT_MODE_ACTIVE & ~CONDITION_GROUP_ACTIVE &
        ~LOAD_STROBES[REG_FETCH]) |=> $stable(fetch_ff);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold)
    else $error("fetch counter moved outside repeat mode");

  property p_rpt_clr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(fetch_ff[0]) |=> REPEAT_CLEAR;
  endproperty
  a_rpt_clr: assert property (p_rpt_clr)
    else $error("repeat clear missing after sign drop");

  property p_stop_set;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(table_ff[0]) |=> ##1 PROC_STOP;
  endproperty
  a_stop_set: assert property (p_stop_set)
    else $error("stop not set after table sign drop");

  property p_cmd;
    @(posedge REF_CLK) disable iff (SYS_RST)
      COMMAND_LATCH_STROBE |=> EXTERNAL_ORDER_LINES == $past(order_ff[0:15]);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command latch wrong");

  property p_load_gate;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (~WRITE_REQ & (~CONDITIONAL_STORE_REQ |
        INSTRUCTION_LATCH[COND_INV_BIT])) |-> LOAD_STROBES == 8'h00;
  endproperty
  a_load_gate: assert property (p_load_gate)
    else $error("load strobe without write request");

  property p_idle_bus;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (&READ_STROBES_N) |-> SHARED_READ_BUS_O == BUS_IDLE;
  endproperty
  a_idle_bus: assert property (p_idle_bus)
    else $error("idle bus not all ones");

  property p_unused_test;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (INSTRUCTION_LATCH[14:17] inside {4'h4, 4'h5, 4'h6, 4'h7,
        4'hC, 4'hD, 4'hE}) |-> ~CONDITION_TEST_LINE;
  endproperty
  a_unused_test: assert property (p_unused_test)
    else $error("unused test select reported true");

  property p_stat_read;
    @(posedge REF_CLK) disable iff (SYS_RST)
      ~READ_STROBES_N[REG_FLAGS] |-> SHARED_READ_BUS_O[26:27] ==
        {fetch_neg, table_neg};
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read lost counter conditions");

endmodule // hrs_top

// ==== hdl/hrs_pkg.sv ====
package hrs_pkg;
  // word and field sizes
  localparam int CNT_W = 18;
  localparam int FLAG_W = 7;
  localparam int CMD_W = 16;
  localparam int ASYNC_W = 10;
  // higher register indices (registers 10-17 octal map to 0-7)
  localparam logic [2:0] REG_FETCH = 3'h0;
  localparam logic [2:0] REG_TABLE = 3'h1;
  localparam logic [2:0] REG_ORDER = 3'h2;
  localparam logic [2:0] REG_FLAGS = 3'h4;
  localparam logic [2:0] REG_MEMADDR = 3'h5;
  // bus and instruction bit positions, bit 0 is the most significant
  localparam int FLAG_LO = 18;
  localparam int FETCH_COND_BIT = 26;
  localparam int TABLE_COND_BIT = 27;
  localparam int TOUCH_BIT = 28;
  localparam int AUX_BIT = 29;
  localparam int STOP_BIT = 33;
  localparam int COND_INV_BIT = 13;
  // flag word slots
  localparam int FW_TOUCH = 4;
  localparam int FW_AUX = 5;
  localparam int FW_STOP = 6;
  // test selects
  localparam logic [3:0] TS_FETCH = 4'h8;
  localparam logic [3:0] TS_TABLE = 4'h9;
  localparam logic [3:0] TS_TOUCH = 4'hA;
  localparam logic [3:0] TS_AUX = 4'hB;
  localparam logic [3:0] TS_STOP = 4'hF;
  // asynchronous input slots
  localparam int AI_HOST = 0;
  localparam int AI_SETSTOP = 1;
  localparam int AI_CLRSTOP = 2;
  localparam int AI_STEP = 3;
  localparam int AI_CLIPCLK = 4;
  localparam int AI_SETTOUCH = 5;
  localparam int AI_SETAUX = 6;
  localparam int AI_CLRAUX = 7;
  localparam int AI_CLRTOUCH = 8;
  localparam int AI_BADSLAVE = 9;
  // reset values
  localparam logic [0:17] CNT_RST = 18'h00000;
  localparam logic [0:6] FLAG_RST = 7'h00;
  localparam logic [0:15] CMD_RST = 16'h0000;
  localparam logic [0:35] BUS_IDLE = 36'hFFFFFFFFF;
endpackage

// ==== dv/hrs_far_end.sv ====
`timescale 1ns/10ps
// stand-in for host i/o and clipper; every level is held 6 cycles
// so the 3-flop synchronisers inside always catch it
module hrs_far_end (
  input wire logic clk, // pacing clock
  output logic ctl, // host control strobe
  output logic sset, // host set stop
  output logic sclr, // host clear stop
  output logic step, // host single step
  output logic ctch, // clear touch request
  output logic cclk, // clipper clock, acts on fall
  output logic stch, // clipper set touch
  output logic saux, // clipper set aux
  output logic caux, // clipper clear aux
  output logic bad // bad slave select fault
);
  initial begin
    ctl = 1'b0;
    sset = 1'b0;
    sclr = 1'b0;
    step = 1'b0;
    ctch = 1'b0;
    cclk = 1'b0;
    stch = 1'b0;
    saux = 1'b0;
    caux = 1'b0;
    bad = 1'b0;
  end
  task automatic hold();
    repeat (6) @(negedge clk);
  endtask
  // host request, then a quiet gap; set and clear never asked together
  task automatic host(logic [0:4] v);
    ctl = v[0];
    sset = v[1];
    sclr = v[2];
    step = v[3];
    ctch = v[4];
    hold();
    ctl = 1'b0;
    sset = 1'b0;
    sclr = 1'b0;
    step = 1'b0;
    ctch = 1'b0;
    hold();
  endtask
  // clipper clock stands low outside a pulse
  task automatic clip(logic [0:2] v);
    stch = v[0];
    saux = v[1];
    caux = v[2];
    hold();
    cclk = !cclk;
    hold();
    cclk = !cclk;
    hold();
    stch = 1'b0;
    saux = 1'b0;
    caux = 1'b0;
  endtask
  task automatic fault(logic v);
    bad = v;
    hold();
  endtask
endmodule // hrs_far_end

// ==== dv/higher_register_set_test.sv ====
`timescale 1ns/10ps
module higher_register_set_test;
  import hrs_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [0:35] ibus = '0;
  logic [0:17] instr = '0;
  logic [2:0] addr = '0;
  logic rdq = 0, wrq = 0, cwr = 0, map = 0, fen = 0, ten = 0;
  logic rep = 0, jm = 0, grp = 0, cstb = 0, m2m = 0, hot = 0;
  logic ctl, sset, sclr, step, ctch, cclk, stch, saux, caux, bad;
  logic [0:35] bo, boe, q;
  logic io, ioe, tl, cok, rclr, pstop, hss, hst;
  logic [0:7] rsn, lds;
  logic [0:6] fsw;
  logic [0:6] mf = '0;
  logic [0:15] mcmd = '0;
  logic [0:15] ord;
  int errors = 0, n_compared = 0;
  int mfe = 0, mta = 0, mor = 0, i;

  // 25 MHz processor clock
  initial begin
    forever #20 clk = ~clk;
  end

  hrs_far_end far (.clk(clk), .ctl(ctl), .sset(sset), .sclr(sclr),
    .step(step), .ctch(ctch), .cclk(cclk), .stch(stch), .saux(saux),
    .caux(caux), .bad(bad));

  hrs_top uut (
    .REF_CLK(clk), .SYS_RST(rst), .REGISTER_INPUT_BUS(ibus),
    .INSTRUCTION_LATCH(instr), .HIGH_REG_ADDR(addr), .READ_REQ(rdq),
    .WRITE_REQ(wrq), .CONDITIONAL_STORE_REQ(cwr),
    .MEMADDR_TO_REGISTER_PATH(map), .FETCH_COUNT_ENABLE(fen),
    .TABLE_COUNT_ENABLE(ten), .REPEAT_MODE_ACTIVE(rep),
    .J_CONDITION_MODE(jm), .CONDITION_GROUP_ACTIVE(grp),
    .COMMAND_LATCH_STROBE(cstb), .MEM_TO_MEM(m2m), .HALT_ON_TOUCH(hot),
    .HOST_CONTROL_STROBE(ctl), .HOST_SET_STOP(sset),
    .HOST_CLEAR_STOP(sclr), .HOST_STEP(step), .CLIPPER_CLOCK_PULSE(cclk),
    .CLIPPER_SET_TOUCH(stch), .CLIPPER_SET_AUX(saux),
    .CLIPPER_CLEAR_AUX(caux), .CLEAR_TOUCH_REQUEST(ctch),
    .BAD_SLAVE_SELECT(bad), .SHARED_READ_BUS_I(bo),
    .SHARED_READ_BUS_O(bo), .SHARED_READ_BUS_OE(boe),
    .INTERRUPT_OR_LINE_O(io), .INTERRUPT_OR_LINE_OE(ioe),
    .READ_STROBES_N(rsn), .LOAD_STROBES(lds), .CONDITION_TEST_LINE(tl),
    .COND_OK(cok), .FLAG_STATUS_WORD(fsw), .EXTERNAL_ORDER_LINES(ord),
    .REPEAT_CLEAR(rclr), .PROC_STOP(pstop), .HOST_STOP_SET(hss),
    .HOST_STEP_SET(hst)
  );

  task automatic chk(string nm, logic [35:0] s, logic [35:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // negative but not minus one, from the sign and all lower bits
  function automatic logic nn(int x);
    return x[17] && x != 'h3FFFF;
  endfunction

  // one load; strobes drop at the next fall and an idle edge follows
  task automatic wr(logic [2:0] a, int d, logic c);
    addr = a;
    ibus = {18'h3FFFF, d[17:0]};
    cwr = c;
    wrq = !c;
    @(negedge clk);
    wrq = 1'b0;
    cwr = 1'b0;
    @(negedge clk);
    if (c && instr[13]) return;
    case (a)
      REG_FETCH: mfe = d & 'h3FFFF;
      REG_TABLE: mta = d & 'h3FFFF;
      REG_ORDER: mor = d & 'h3FFFF;
      REG_FLAGS: mf = {d[17:14], d[7], d[6], d[2]};
      default: ;
    endcase
  endtask

  task automatic rd(logic [2:0] a);
    addr = a;
    rdq = 1;
    #2 q = bo;
    #2 rdq = 0;
    @(negedge clk);
  endtask

  task automatic cnt(logic f, logic t, logic r, logic g, logic j);
    fen = f;
    ten = t;
    rep = r;
    grp = g;
    jm = j;
    @(negedge clk);
    fen = 1'b0;
    ten = 1'b0;
    rep = 1'b0;
    grp = 1'b0;
    jm = 1'b0;
    @(negedge clk);
    if (f && (r || (g && j))) mfe = (mfe + 1) & 'h3FFFF;
    if (t || (g && j)) mta = (mta + 1) & 'h3FFFF;
  endtask

  // read every register back and walk all sixteen test selects
  task automatic scan();
    logic e;
    logic [8:0] ex;
    rd(REG_FETCH);
    chk("fetch", q[18:35], mfe);
    rd(REG_TABLE);
    chk("table", q[18:35], mta);
    rd(REG_ORDER);
    chk("order", q[18:35], mor);
    rd(REG_FLAGS);
    ex = {mf[0:3], nn(mfe), nn(mta), mf[4:6]};
    chk("status read", {q[18:21], q[26:29], q[33]}, ex);
    chk("flags", fsw, mf);
    for (int s = 0; s < 16; s++) begin
      instr[13:17] = {s[0], s[3:0]};
      case (s)
        0, 1, 2, 3: e = mf[s];
        8: e = nn(mfe);
        9: e = nn(mta);
        10: e = mf[4];
        11: e = mf[5];
        15: e = mf[6];
        default: e = 0;
      endcase
      #1 chk("test line", tl, e);
      chk("cond ok", cok, e ^ s[0]);
    end
    instr = '0;
    @(negedge clk);
  endtask

  function automatic logic sig(int k);
    return k == 0 ? rclr : k == 1 ? pstop : k == 2 ? hss : hst;
  endfunction

  // bounded wait for a synchronised level; a miss ends the run
  task automatic wt(int k, logic e);
    for (int n = 0; n < 12 && sig(k) !== e; n++) @(negedge clk);
    chk("sync level", sig(k), e);
    if (sig(k) !== e) wrap_up();
  endtask

  initial begin
    i = $urandom(50261);
    repeat (4) @(negedge clk);
    rst = 0;
    chk("idle bus", bo, BUS_IDLE);
    chk("idle oe", boe, 36'h000000000);
    chk("interrupt level", io, 0);
    scan();
    // counters kept positive here so no sign edge fires
    for (int it = 0; it < 3; it++) begin
      wr(REG_FETCH, $urandom & 'h1FFFF, 0);
      wr(REG_TABLE, $urandom & 'h1FFFF, 0);
      wr(REG_ORDER, $urandom, 0);
      wr(REG_FLAGS, $urandom & 'h3FFFB, 0);
      scan();
      // middle pass skips the strobe so the latch must hold
      cstb = it != 1;
      if (cstb) mcmd = mor[17:2];
      @(negedge clk);
      cstb = 0;
      @(negedge clk);
      chk("order lines", ord, mcmd);
    end
    wr(REG_FETCH, 'h0FFFF, 0);
    wr(REG_TABLE, 'h1FFFE, 0);
    wr(REG_FLAGS, 0, 0);
    cnt(1, 1, 0, 0, 0);
    cnt(1, 0, 1, 0, 0);
    cnt(1, 1, 0, 1, 0);
    cnt(1, 1, 0, 1, 1);
    scan();
    instr[13] = 1;
    wr(REG_ORDER, 'h2AAAA, 1);
    instr[13] = 0;
    wr(REG_ORDER, 'h15555, 1);
    scan();
    for (int a = 0; a < 8; a++) begin
      addr = a[2:0];
      rdq = a != 4;
      wrq = a == 3 || a > 4;
      #2 chk("read strobes", rsn, rdq ? 8'(~(8'h80 >> a)) : 8'hFF);
      chk("load strobes", lds, wrq ? 8'h80 >> a : 8'h00);
      rdq = 1'b0;
      wrq = 1'b0;
      map = a != 2;
      #2 chk("memaddr read", rsn, map ? 8'hFB : 8'hFF);
      map = 0;
      @(negedge clk);
    end
    wr(REG_FETCH, 'h3FFFF, 0);
    cnt(1, 0, 1, 0, 0);
    wt(0, 1);
    @(negedge clk);
    chk("repeat clear", rclr, 0);
    // table preset to minus one word, so one more count stops the run
    wr(REG_TABLE, 'h3FFFF, 0);
    cnt(0, 1, 0, 0, 0);
    wt(1, 1);
    for (int r = 0; r < 4; r++) begin
      m2m = r[0];
      #2 chk("table interrupt", ioe, r[0]);
    end
    m2m = 0;
    @(negedge clk);
    far.host(5'b00100);
    wt(1, 0);
    far.host(5'b01000);
    wt(2, 1);
    wt(1, 1);
    far.host(5'b00100);
    wt(2, 0);
    far.host(5'b00010);
    wt(3, 1);
    far.host(5'b00100);
    wt(3, 0);
    far.clip(3'b100);
    mf[4] = 1;
    chk("touch", fsw[4], 1);
    for (int h = 0; h < 2; h++) begin
      hot = h[0];
      #2 chk("touch interrupt", ioe, h[0]);
    end
    far.host(5'b10001);
    mf[4] = 0;
    chk("touch interrupt", ioe, 0);
    hot = 0;
    far.clip(3'b010);
    mf[5] = 1;
    scan();
    far.clip(3'b001);
    mf[5] = 0;
    scan();
    wr(REG_FLAGS, 'h00004, 0);
    chk("stop interrupt", ioe, 1);
    wr(REG_FLAGS, 0, 0);
    far.fault(1);
    chk("fault interrupt", ioe, 1);
    far.fault(0);
    chk("no interrupt", ioe, 0);
    far.host(5'b00100);
    wt(1, 0);
    wrap_up();
  end

  // hang guard
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule // higher_register_set_test
